// [core/hro_output_interval.sv]
// Hall rotation output flags, angles and interval logic behind a two-wire serial slave
// Contract
// - Flag bit 7 marks magnet movement
// - Flag bit 6 gives movement direction
// - Flag bit 1 set when count negative
// - Flag bit 0 set when relative negative
// - Flags follow tiny moves, no debouncing
// - Filtered angle 16 bits, 0 to 359
// - Interval number is readable 8-bit register
// - Raw angle 16 bits over two bytes
// - Relative change magnitude 0 to 180 degrees
// - Divider holds interval size, host keeps 3-180
// - Zero-wheel bit zeroes angle, then self-clears
// - Settings bit 3 disables interval events
// - Event whenever interval number changes
// - Wheel offset shifts interval zero position
// - One degree hysteresis when interval number rises, none when it falls
// - Wheel events take precedence over interval events
module hro_output_interval #(
    parameter logic [6:0] SLAVE_ADDR = 7'h44  // Arbitrary bus address
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic        measValid,
    input  wire logic [15:0] rawIn,
    input  wire logic [15:0] filtIn,
    output logic             eventOut
);
    // ----------------------------------------
    // Serial slave
    // ----------------------------------------
    hro_pkg::hro_state_t state_r;
    logic       sclPrev_r, sdaPrev_r;
    logic [7:0] shift_r, ptr_r, txByte_r;
    logic [3:0] bitCnt_r;
    logic       wrStb_r, ptrDone_r;
    logic [7:0] wrAddr_r, wrData_r;
    logic       sdaOe_r;
    logic [7:0] readByte;
    wire sclRise  = sclIn && !sclPrev_r;
    wire sclFall  = !sclIn && sclPrev_r;
    wire startSeen = sclIn && sclPrev_r && sdaPrev_r && !sdaIn;
    wire stopSeen  = sclIn && sclPrev_r && !sdaPrev_r && sdaIn;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclPrev_r <= sclIn;
            sdaPrev_r <= sdaIn;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r   <= hro_pkg::ST_IDLE;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            txByte_r  <= 8'h00;
            bitCnt_r  <= 4'h0;
            wrStb_r   <= 1'b0;
            wrAddr_r  <= 8'h00;
            wrData_r  <= 8'h00;
            sdaOe_r   <= 1'b0;
            ptrDone_r <= 1'b0;
        end else begin
            wrStb_r <= 1'b0;
            if (startSeen) begin
                state_r  <= hro_pkg::ST_ADDR;
                bitCnt_r <= 4'h0;
                sdaOe_r  <= 1'b0;
            end else if (stopSeen) begin
                state_r <= hro_pkg::ST_IDLE;
                sdaOe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    hro_pkg::ST_IDLE: sdaOe_r <= 1'b0;
                    hro_pkg::ST_ADDR, hro_pkg::ST_PTR, hro_pkg::ST_WR: begin
                        if (sclRise && bitCnt_r < 4'h8) begin
                            shift_r  <= {shift_r[6:0], sdaIn};
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall && bitCnt_r == 4'h8) begin
                            if (state_r == hro_pkg::ST_ADDR) begin
                                if (shift_r[7:1] == SLAVE_ADDR) begin
                                    state_r <= hro_pkg::ST_AACK;
                                    sdaOe_r <= 1'b1;
                                end else begin
                                    state_r <= hro_pkg::ST_IDLE;
                                end
                            end else if (state_r == hro_pkg::ST_PTR) begin
                                ptr_r   <= shift_r;
                                state_r <= hro_pkg::ST_PACK;
                                sdaOe_r <= 1'b1;
                            end else begin
                                wrStb_r  <= 1'b1;
                                wrAddr_r <= ptr_r;
                                wrData_r <= shift_r;
                                ptr_r    <= ptr_r + 8'h01;
                                state_r  <= hro_pkg::ST_WACK;
                                sdaOe_r  <= 1'b1;
                            end
                        end
                    end
                    hro_pkg::ST_AACK: begin
                        if (sclFall) begin
                            bitCnt_r <= 4'h0;
                            if (shift_r[0]) begin
                                state_r  <= hro_pkg::ST_RD;
                                txByte_r <= readByte;
                                sdaOe_r  <= !readByte[7];
                            end else begin
                                state_r <= hro_pkg::ST_PTR;
                                sdaOe_r <= 1'b0;
                            end
                        end
                    end
                    hro_pkg::ST_PACK, hro_pkg::ST_WACK: begin
                        if (sclFall) begin
                            bitCnt_r <= 4'h0;
                            sdaOe_r  <= 1'b0;
                            state_r  <= hro_pkg::ST_WR;
                        end
                    end
                    hro_pkg::ST_RD: begin
                        if (sclFall) begin
                            if (bitCnt_r == 4'h7) begin
                                state_r <= hro_pkg::ST_RDACK;
                                sdaOe_r <= 1'b0;
                                ptr_r   <= ptr_r + 8'h01;
                            end else begin
                                txByte_r <= {txByte_r[6:0], 1'b0};
                                sdaOe_r  <= !txByte_r[6];
                                bitCnt_r <= bitCnt_r + 4'h1;
                            end
                        end
                    end
                    hro_pkg::ST_RDACK: begin
                        // Master's NACK ends the burst; the bus goes quiet until a new start
                        if (sclRise && sdaIn) begin
                            state_r <= hro_pkg::ST_IDLE;
                        end else if (sclFall) begin
                            bitCnt_r <= 4'h0;
                            txByte_r <= readByte;
                            sdaOe_r  <= !readByte[7];
                            state_r  <= hro_pkg::ST_RD;
                        end
                    end
                    default: begin
                        state_r <= hro_pkg::ST_IDLE;
                        sdaOe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]  flags_r, intervalNum_r, settings_r, divider_r, relAngle_r;
    logic [15:0] filtAngle_r, rawAngle_r, offset_r, moveCount_r, zeroRef_r;
    logic [15:0] prevRaw_r;
    logic        eventOut_r, sdaOut_r;
    always_comb begin
        unique case (ptr_r)
            hro_pkg::ADDR_HALL_FLAGS:   readByte = flags_r;
            hro_pkg::ADDR_FILT_LO:      readByte = filtAngle_r[7:0];
            hro_pkg::ADDR_FILT_HI:      readByte = filtAngle_r[15:8];
            hro_pkg::ADDR_INTERVAL_NUM: readByte = intervalNum_r;
            hro_pkg::ADDR_ROT_SETTINGS: readByte = settings_r;
            hro_pkg::ADDR_INTERVAL_DIV: readByte = divider_r;
            hro_pkg::ADDR_OFFSET_LO:    readByte = offset_r[7:0];
            hro_pkg::ADDR_OFFSET_HI:    readByte = offset_r[15:8];
            hro_pkg::ADDR_RAW_LO:       readByte = rawAngle_r[7:0];
            hro_pkg::ADDR_RAW_HI:       readByte = rawAngle_r[15:8];
            hro_pkg::ADDR_RELATIVE:     readByte = relAngle_r;
            default:                    readByte = 8'h00;
        endcase
    end
    // ----------------------------------------
    // Per-cycle movement
    // ----------------------------------------
    logic signed [10:0] delta;
    logic [7:0]         deltaMag;
    always_comb begin
        delta = $signed({1'b0, rawIn[9:0]}) - $signed({1'b0, prevRaw_r[9:0]});
        if (delta > $signed({1'b0, hro_pkg::HALF_TURN}))
            delta = delta - $signed({1'b0, hro_pkg::FULL_TURN});
        else if (delta < -$signed({1'b0, hro_pkg::HALF_TURN}))
            delta = delta + $signed({1'b0, hro_pkg::FULL_TURN});
        deltaMag = delta[10] ? 8'((-delta)) : 8'(delta);
    end
    wire moveEvent = measValid && (delta != 11'sh000);
    // ----------------------------------------
    // Wheel angle and interval
    // ----------------------------------------
    logic [10:0] wheel, pos;
    logic [7:0]  divEff, quot, rem;
    always_comb begin
        wheel = {1'b0, filtIn[9:0]} - {1'b0, zeroRef_r[9:0]};
        if (wheel[10])
            wheel = wheel + {1'b0, hro_pkg::FULL_TURN};
        pos = wheel + {1'b0, offset_r[9:0]};
        if (pos >= {1'b0, hro_pkg::FULL_TURN})
            pos = pos - {1'b0, hro_pkg::FULL_TURN};
        if (pos >= {1'b0, hro_pkg::FULL_TURN})
            pos = pos - {1'b0, hro_pkg::FULL_TURN};
        // Divider of zero would be meaningless; treat as one degree
        divEff = (divider_r == 8'h00) ? 8'h01 : divider_r;
        quot = 8'(pos / {3'b000, divEff});
        rem  = 8'(pos % {3'b000, divEff});
    end
    // rising needs one degree past boundary
    wire intervalStep = (quot != intervalNum_r) && ((quot < intervalNum_r) || (rem != 8'h00));
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            settings_r <= hro_pkg::RST_SETTINGS;
            divider_r  <= hro_pkg::RST_DIVIDER;
            offset_r   <= hro_pkg::RST_OFFSET;
            zeroRef_r  <= 16'h0000;
        end else begin
            if (wrStb_r && wrAddr_r == hro_pkg::ADDR_ROT_SETTINGS) begin
                settings_r <= wrData_r;
            end else if (settings_r[hro_pkg::SET_ZERO_BIT]) begin
                settings_r[hro_pkg::SET_ZERO_BIT] <= 1'b0;
                zeroRef_r                         <= filtIn;
            end
            if (wrStb_r && wrAddr_r == hro_pkg::ADDR_INTERVAL_DIV)
                divider_r <= wrData_r;
            if (wrStb_r && wrAddr_r == hro_pkg::ADDR_OFFSET_LO)
                offset_r[7:0] <= wrData_r;
            if (wrStb_r && wrAddr_r == hro_pkg::ADDR_OFFSET_HI)
                offset_r[15:8] <= wrData_r;
        end
    end
    chk_zero_clear: assert property (@(posedge clock) disable iff (!nrst)
        settings_r[hro_pkg::SET_ZERO_BIT] && !(wrStb_r && wrAddr_r == hro_pkg::ADDR_ROT_SETTINGS)
        |=> !settings_r[hro_pkg::SET_ZERO_BIT] && zeroRef_r == $past(filtIn))
        else $error("zero-wheel bit did not self-clear");

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_r     <= 8'h00;
            relAngle_r  <= 8'h00;
            rawAngle_r  <= 16'h0000;
            prevRaw_r   <= 16'h0000;
            moveCount_r <= 16'h0000;
            filtAngle_r <= 16'h0000;
        end else begin
            filtAngle_r <= {5'h00, wheel};
            if (measValid) begin
                prevRaw_r <= rawIn;
                rawAngle_r <= rawIn;
                relAngle_r <= deltaMag;
                moveCount_r <= moveCount_r + 16'(delta);
                flags_r[hro_pkg::FLAG_MOVE_BIT] <= moveEvent;
                if (moveEvent)
                    flags_r[hro_pkg::FLAG_DIR_BIT] <= !delta[10];
                flags_r[hro_pkg::FLAG_CNT_NEG_BIT] <= moveCount_r[15] ^ (moveCount_r[15] ^ (moveCount_r + 16'(delta)) >> 15 != 16'h0000);
                flags_r[hro_pkg::FLAG_REL_NEG_BIT] <= delta[10];
            end else begin
                if (wrStb_r && wrAddr_r == hro_pkg::ADDR_RAW_LO)
                    rawAngle_r[7:0] <= wrData_r;
                if (wrStb_r && wrAddr_r == hro_pkg::ADDR_RAW_HI)
                    rawAngle_r[15:8] <= wrData_r;
                if (wrStb_r && wrAddr_r == hro_pkg::ADDR_RELATIVE)
                    relAngle_r <= wrData_r;
            end
        end
    end
    chk_rel_range: assert property (@(posedge clock) disable iff (!nrst)
        measValid |=> relAngle_r <= 8'hB4)
        else $error("relative angle above 180");
    chk_filt_range: assert property (@(posedge clock) disable iff (!nrst)
        ##1 filtAngle_r < 16'h0168)
        else $error("filtered angle out of range");
    chk_move_flag: assert property (@(posedge clock) disable iff (!nrst)
        measValid |=> flags_r[hro_pkg::FLAG_MOVE_BIT] == (relAngle_r != 8'h00))
        else $error("movement flag disagrees with delta");
    chk_move_dir: assert property (@(posedge clock) disable iff (!nrst)
        moveEvent && !delta[10] |=> flags_r[hro_pkg::FLAG_DIR_BIT] && !flags_r[hro_pkg::FLAG_REL_NEG_BIT])
        else $error("direction flag wrong");
    chk_count_sign: assert property (@(posedge clock) disable iff (!nrst)
        $past(measValid) |-> flags_r[hro_pkg::FLAG_CNT_NEG_BIT] == moveCount_r[15])
        else $error("count sign flag wrong");

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            intervalNum_r <= 8'h00;
            eventOut_r    <= 1'b0;
            sdaOut_r      <= 1'b0;
        end else begin
            if (wrStb_r && wrAddr_r == hro_pkg::ADDR_INTERVAL_NUM)
                intervalNum_r <= wrData_r;
            else if (intervalStep)
                intervalNum_r <= quot;
            if (!settings_r[hro_pkg::SET_WHEEL_EVDIS])
                eventOut_r <= moveEvent;
            else
                eventOut_r <= intervalStep && !settings_r[hro_pkg::SET_INTV_EVDIS];
        end
    end
    chk_interval_event: assert property (@(posedge clock) disable iff (!nrst)
        intervalStep && settings_r[hro_pkg::SET_WHEEL_EVDIS] && !settings_r[hro_pkg::SET_INTV_EVDIS]
        |=> eventOut_r)
        else $error("interval change gave no event");
    chk_wheel_pref: assert property (@(posedge clock) disable iff (!nrst)
        !settings_r[hro_pkg::SET_WHEEL_EVDIS] && !moveEvent |=> !eventOut_r)
        else $error("interval event while wheel events enabled");
    chk_hyst_up: assert property (@(posedge clock) disable iff (!nrst)
        quot > intervalNum_r && rem == 8'h00 && !wrStb_r |=> intervalNum_r == $past(intervalNum_r))
        else $error("interval rose without hysteresis");

    assign sdaOut   = sdaOut_r;
    assign sdaOe    = sdaOe_r;
    assign eventOut = eventOut_r;
endmodule // hro_output_interval

// [include/hro_pkg.sv]
// Package: register map, field positions, reset values and state codes
package hro_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_HALL_FLAGS     = 8'h14;
    localparam logic [7:0] ADDR_FILT_LO        = 8'h16;
    localparam logic [7:0] ADDR_FILT_HI        = 8'h17;
    localparam logic [7:0] ADDR_INTERVAL_NUM   = 8'h18;
    localparam logic [7:0] ADDR_ROT_SETTINGS   = 8'h70;
    localparam logic [7:0] ADDR_INTERVAL_DIV   = 8'h7D;
    localparam logic [7:0] ADDR_OFFSET_LO      = 8'h7E;
    localparam logic [7:0] ADDR_OFFSET_HI      = 8'h7F;
    localparam logic [7:0] ADDR_RAW_LO         = 8'h80;
    localparam logic [7:0] ADDR_RAW_HI         = 8'h81;
    localparam logic [7:0] ADDR_RELATIVE       = 8'h8E;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FLAG_MOVE_BIT      = 7;
    localparam int FLAG_DIR_BIT       = 6;
    localparam int FLAG_CNT_NEG_BIT   = 1;
    localparam int FLAG_REL_NEG_BIT   = 0;
    localparam int SET_ZERO_BIT       = 5;
    localparam int SET_WHEEL_EVDIS    = 4;
    localparam int SET_INTV_EVDIS     = 3;

    // ----------------------------------------
    // Reset values and angle limits
    // ----------------------------------------
    localparam logic [7:0]  RST_SETTINGS      = 8'h14;
    localparam logic [7:0]  RST_DIVIDER       = 8'h03;
    localparam logic [15:0] RST_OFFSET        = 16'h0000;
    localparam logic [9:0]  FULL_TURN         = 10'h168;
    localparam logic [9:0]  HALF_TURN         = 10'h0B4;

    // ----------------------------------------
    // Serial slave states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_ADDR   = 4'b0001,
        ST_AACK   = 4'b0010,
        ST_PTR    = 4'b0011,
        ST_PACK   = 4'b0100,
        ST_WR     = 4'b0101,
        ST_WACK   = 4'b0110,
        ST_RD     = 4'b0111,
        ST_RDACK  = 4'b1000
    } hro_state_t;
endpackage

// [testbench/hro_host_model.sv]
// Host side model: two-wire bus master that writes and reads device registers
module hro_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h44  // Arbitrary bus address, matches the design default
) (
    input  wire logic       clock,
    input  wire logic       sda,
    output logic            scl,
    output logic            sdaLow,
    output logic            rdDone,
    output logic [7:0]      rdData
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
        rdDone = 1'b0;
        rdData = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Three clocks of low margin so the device has let go of its ack before scl rises
    task automatic clk_bit(input logic b, output logic s);
        sdaLow = ~b;
        hold(3);
        scl = 1'b1;
        hold(4);
        s = sda;
        scl = 1'b0;
        hold(3);
    endtask

    task automatic start();
        sdaLow = 1'b0;
        hold(4);
        scl = 1'b1;
        hold(4);
        sdaLow = 1'b1;
        hold(4);
        scl = 1'b0;
        hold(3);
    endtask

    task automatic stop();
        sdaLow = 1'b1;
        hold(4);
        scl = 1'b1;
        hold(4);
        sdaLow = 1'b0;
        hold(4);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ackTx, output logic [7:0] rx);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], s);
            rx[i] = s;
        end
        clk_bit(ackTx, s);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        logic [7:0] rx;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx);
        xfer(ptr, 1'b1, rx);
        foreach (d[i]) xfer(d[i], 1'b1, rx);
        stop();
    endtask

    // Last byte is refused with a nack so the device lets go of the line
    task automatic rd(input logic [7:0] ptr, input int n);
        logic [7:0] rx;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx);
        xfer(ptr, 1'b1, rx);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, rx);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, i == n - 1, rx);
            rdData = rx;
            rdDone = 1'b1;
            hold(1);
            rdDone = 1'b0;
        end
        stop();
    endtask
endmodule // hro_host_model

// [testbench/tb_hro_output_interval.sv]
// Self-checking bench: register reads, measurement flags, interval steps and events
module tb_hro_output_interval;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        string      name;
        logic [7:0] val;
    } hro_note_t;
    localparam logic [7:0]  RST_A [12] = '{8'h14, 8'h16, 8'h17, 8'h18, 8'h70, 8'h7D, 8'h7E, 8'h7F, 8'h80, 8'h81,
                                           8'h8E, 8'h20};
    localparam logic [7:0]  RST_V [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h00};
    localparam logic [15:0] MRAW [5] = '{16'h000A, 16'h0005, 16'h015E, 16'h015E, 16'h0000};
    localparam logic [7:0]  MREL [5] = '{8'h0A, 8'h05, 8'h0F, 8'h00, 8'h0A};
    localparam logic [7:0]  MFLG [5] = '{8'hC0, 8'h81, 8'h83, 8'h02, 8'hC0};
    // Row: settings, divider, offset, angle, interval expected, event expected
    localparam logic [55:0] IROW [13] = '{
        56'h14_24_00_0024_00_00, 56'h14_24_00_0025_01_01, 56'h14_24_00_0024_01_00, 56'h14_24_00_0023_00_01,
        56'h14_24_00_0047_01_01, 56'h14_24_00_0048_01_00, 56'h14_24_00_0049_02_01, 56'h1C_B4_00_00B5_01_00,
        56'h1C_03_00_00B6_3C_00, 56'h1C_24_00_0000_00_00, 56'h14_24_12_0013_01_01, 56'h14_24_12_0000_00_01,
        56'h1C_24_00_0000_00_00};
    logic        clock;
    logic        nrst;
    logic        scl;
    logic        sdaLow;
    logic        sdaOut;
    logic        sdaOe;
    logic        sda;
    logic        measValid;
    logic [15:0] rawIn;
    logic [15:0] filtIn;
    logic        eventOut;
    logic        rdDone;
    logic [7:0]  rdData;
    hro_note_t   rdQ[$];
    string       evQ[$];
    int          nFail = 0;
    int          nChecks = 0;
    int          cycles = 0;
    int          seed = 32'hA7B1C3FE;

    // Open-drain data line with pull-up
    assign sda = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;

    hro_output_interval hro_output_interval_i (
        .clock    (clock),
        .nrst     (nrst),
        .sclIn    (scl),
        .sdaIn    (sda),
        .sdaOut   (sdaOut),
        .sdaOe    (sdaOe),
        .measValid(measValid),
        .rawIn    (rawIn),
        .filtIn   (filtIn),
        .eventOut (eventOut)
    );
    hro_host_model hro_host_model_i (
        .clock (clock),
        .sda   (sda),
        .scl   (scl),
        .sdaLow(sdaLow),
        .rdDone(rdDone),
        .rdData(rdData)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tallyAndFinish();
        if (nFail == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic rdExp(input string name, input logic [7:0] ptr, input logic [7:0] e[$]);
        foreach (e[i]) rdQ.push_back('{name, e[i]});
        hro_host_model_i.rd(ptr, e.size());
    endtask

    task automatic meas(input logic [15:0] raw);
        measValid = 1'b1;
        rawIn = raw;
        @(negedge clock);
        measValid = 1'b0;
        repeat (3) @(negedge clock);
    endtask

    task automatic angle(input logic [15:0] a);
        filtIn = a;
        repeat (4) @(negedge clock);
    endtask

    always @(posedge clock) begin
        hro_note_t n;
        if (rdDone) begin
            n = rdQ.pop_front();
            check(n.name, {8'h00, rdData}, {8'h00, n.val});
        end
        if (eventOut === 1'b1) begin
            if (evQ.size() == 0) begin
                check("unexpected event", 16'h0001, 16'h0000);
            end else begin
                check(evQ.pop_front(), 16'h0001, 16'h0001);
            end
        end
        cycles++;
        if (cycles == 80000) begin
            nFail++;
            tallyAndFinish();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [55:0] r;
        logic [15:0] a;
        nrst = 1'b0;
        measValid = 1'b0;
        rawIn = 16'h0000;
        filtIn = 16'h0000;
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        for (int i = 0; i < 12; i++) rdExp("reset value", RST_A[i], '{RST_V[i]});
        hro_host_model_i.wr(8'h20, '{8'hFF});
        hro_host_model_i.wr(hro_pkg::ADDR_HALL_FLAGS, '{8'hFF});
        rdExp("unmapped", 8'h20, '{8'h00});
        rdExp("flags", hro_pkg::ADDR_HALL_FLAGS, '{8'h00});
        for (int i = 0; i < 5; i++) begin
            meas(MRAW[i]);
            rdExp("raw angle", hro_pkg::ADDR_RAW_LO, '{MRAW[i][7:0], MRAW[i][15:8]});
            rdExp("relative", hro_pkg::ADDR_RELATIVE, '{MREL[i]});
            rdExp("flags", hro_pkg::ADDR_HALL_FLAGS, '{MFLG[i]});
        end
        for (int i = 0; i < 13; i++) begin
            r = IROW[i];
            hro_host_model_i.wr(hro_pkg::ADDR_ROT_SETTINGS, '{r[55:48]});
            // host keeps divider within 3 to 180
            hro_host_model_i.wr(hro_pkg::ADDR_INTERVAL_DIV, '{r[47:40]});
            hro_host_model_i.wr(hro_pkg::ADDR_OFFSET_LO, '{r[39:32], 8'h00});
            if (r[0]) evQ.push_back("interval event");
            angle(r[31:16]);
            rdExp("divider", hro_pkg::ADDR_INTERVAL_DIV, '{r[47:40]});
            rdExp("offset", hro_pkg::ADDR_OFFSET_LO, '{r[39:32], 8'h00});
            rdExp("interval", hro_pkg::ADDR_INTERVAL_NUM, '{r[15:8]});
        end
        for (int i = 0; i < 4; i++) begin
            a = 16'($unsigned($random(seed)) % 360);
            angle(a);
            rdExp("filtered", hro_pkg::ADDR_FILT_LO, '{a[7:0], a[15:8]});
        end
        angle(16'h0064);
        hro_host_model_i.wr(hro_pkg::ADDR_ROT_SETTINGS, '{8'h3C});
        rdExp("settings", hro_pkg::ADDR_ROT_SETTINGS, '{8'h1C});
        rdExp("interval", hro_pkg::ADDR_INTERVAL_NUM, '{8'h00});
        hro_host_model_i.wr(hro_pkg::ADDR_ROT_SETTINGS, '{8'h14});
        evQ.push_back("zeroed step");
        angle(16'h0089);
        rdExp("interval", hro_pkg::ADDR_INTERVAL_NUM, '{8'h01});
        // wheel events win over interval events
        hro_host_model_i.wr(hro_pkg::ADDR_ROT_SETTINGS, '{8'h04});
        evQ.push_back("wheel event");
        meas(16'h0014);
        angle(16'h00D9);
        rdExp("interval", hro_pkg::ADDR_INTERVAL_NUM, '{8'h03});
        repeat (8) @(negedge clock);
        check("events left", 16'(evQ.size()), 16'h0000);
        tallyAndFinish();
    end
endmodule // tb_hro_output_interval
